// *** rtl/tc8_params.svh ***
`ifndef TC8_PARAMS_SVH
`define TC8_PARAMS_SVH
// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define TC8_IDX_FLAGS 8'h15
`define TC8_IDX_CTRL_A 8'h24
`define TC8_IDX_CTRL_B 8'h25
`define TC8_IDX_COUNT 8'h26
`define TC8_IDX_CMP_A 8'h27
`define TC8_IDX_CMP_B 8'h28
`define TC8_IDX_MASK 8'h2E
// ************************************************************
// field positions
// ************************************************************
`define TC8_COM_A_HI 7
`define TC8_COM_A_LO 6
`define TC8_COM_B_HI 5
`define TC8_COM_B_LO 4
`define TC8_WGM_HI_BIT 3
`define TC8_FORCE_A_BIT 7
`define TC8_FORCE_B_BIT 6
`define TC8_FLAG_OVF 0
`define TC8_FLAG_A 1
`define TC8_FLAG_B 2
// ************************************************************
// reset values, masks and counts
// ************************************************************
`define TC8_CTRL_A_RST 8'h00
`define TC8_CTRL_B_RST 8'h00
`define TC8_CTRL_A_RMASK 8'hF3
`define TC8_CTRL_B_RMASK 8'h0F
`define TC8_MAX 8'hFF
`define TC8_COUNT_FLOOR 8'h00
`define TC8_PRE_DIV8 3'h7
`define TC8_PRE_DIV64 6'h3F
`define TC8_PRE_DIV256 8'hFF
`define TC8_PRE_DIV1024 10'h3FF
`endif

// *** rtl/tc8_pkg.sv ***
package tc8_pkg;
  typedef enum logic [1:0] {
    TC8_UP = 2'b01,
    TC8_DOWN = 2'b10
  } tc8_dir_t;
  typedef enum logic [2:0] {
    TC8_M_NORMAL = 3'h0,
    TC8_M_PHASE_MAX = 3'h1,
    TC8_M_CLEAR = 3'h2,
    TC8_M_FAST_MAX = 3'h3,
    TC8_M_RSV4 = 3'h4,
    TC8_M_PHASE_A = 3'h5,
    TC8_M_RSV6 = 3'h6,
    TC8_M_FAST_A = 3'h7
  } tc8_mode_t;
endpackage

// *** rtl/tc8_waveform.sv ***
// Behaviour
// - synchronous timer; the tick is a clock enable on the bus clock
// - compare-B match always sets its flag; compare-A flag sets on match
// - clear-on-match and fast mode 7: compare-A match sets flag, clears counter
// - any nonzero output-mode bit routes the wave output to the pin
// - non-PWM output modes: 00 off, 01 toggle, 10 clear, 11 set on match
// - PWM channel A mode 01: off unless mode high bit set, then toggle
// - fast PWM channel A: 10 clear on match, set at wrap; 11 reversed
// - fast PWM channel B: 10 clear match, set wrap; 11 reversed; 01 reserved
// - phase PWM channel A: 10 clear up-match, set down-match; 11 inverted
// - phase PWM channel B: same as A; 01 reserved
// - fast PWM compare equal to limit with upper bit: match ignored, wrap acts
// - phase PWM compare equal to limit with upper bit: act at the limit
// - three-bit mode from control A low bits and control B bit 3
// - mode table: limits 0xFF or compare A; modes 4 and 6 reserved
// - compare buffer update and overflow flag timing per mode
// - control A resets to zero; bits 3 and 2 read zero
// - control B bit 3 holds mode high bit; bits 2..0 pick clock source
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "tc8_params.svh"

module tc8_waveform #(
  parameter int COUNT_W = 8,
  parameter int PRE_W = 10
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic ext_clk_in,
  output logic wave_out_a,
  output logic wave_route_a,
  output logic wave_out_b,
  output logic wave_route_b,
  output logic irq
);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (COUNT_W != 8) begin : g_bad_width
    $error("tc8_waveform: COUNT_W must be 8");
  end
  if (PRE_W < 10) begin : g_bad_pre
    $error("tc8_waveform: PRE_W must be at least 10");
  end

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic is_phase(input logic [2:0] m);
    is_phase = (m == tc8_pkg::TC8_M_PHASE_MAX) || (m == tc8_pkg::TC8_M_PHASE_A);
  endfunction

  function automatic logic is_fast(input logic [2:0] m);
    is_fast = (m == tc8_pkg::TC8_M_FAST_MAX) || (m == tc8_pkg::TC8_M_FAST_A);
  endfunction

  // next level of one wave output for one timer step
  function automatic logic wave_step(
    input logic cur,
    input logic [1:0] com,
    input logic [2:0] m,
    input logic chan_a,
    input logic match,
    input logic up,
    input logic limit_ev,
    input logic cmp_top
  );
    logic r;
    r = cur;
    if (!is_phase(m) && !is_fast(m)) begin
      if (match) begin
        case (com)
          2'b01: r = ~cur;
          2'b10: r = 1'b0;
          2'b11: r = 1'b1;
          default: r = cur;
        endcase
      end
    end else if (com == 2'b01) begin
      // channel B 01 is reserved and left idle
      if (chan_a && m[2] && match) begin
        r = ~cur;
      end
    end else if (com[1]) begin
      if (is_fast(m)) begin
        if (limit_ev) begin
          r = ~com[0];
        end else if (match && !cmp_top) begin
          r = com[0];
        end
      end else begin
        if (cmp_top) begin
          // keeps the level a down-count match would leave, so 10 stays high
          if (limit_ev) begin
            r = ~com[0];
          end
        end else if (match) begin
          r = up ? com[0] : ~com[0];
        end
      end
    end
    wave_step = r;
  endfunction

  function automatic logic [7:0] read_mux(
    input logic [7:0] idx,
    input logic [7:0] ca,
    input logic [7:0] cb,
    input logic [7:0] cnt,
    input logic [7:0] ba,
    input logic [7:0] bb,
    input logic [2:0] fl,
    input logic [2:0] mk
  );
    case (idx)
      `TC8_IDX_CTRL_A: read_mux = ca & `TC8_CTRL_A_RMASK;
      `TC8_IDX_CTRL_B: read_mux = cb & `TC8_CTRL_B_RMASK;
      `TC8_IDX_COUNT: read_mux = cnt;
      `TC8_IDX_CMP_A: read_mux = ba;
      `TC8_IDX_CMP_B: read_mux = bb;
      `TC8_IDX_FLAGS: read_mux = {5'h00, fl};
      `TC8_IDX_MASK: read_mux = {5'h00, mk};
      default: read_mux = 8'h00;
    endcase
  endfunction

  // ************************************************************
  // AHB-Lite slave
  // ************************************************************
  logic dp_valid_r, dp_valid_nxt;
  logic dp_write_r, dp_write_nxt;
  logic dp_ok_r, dp_ok_nxt;
  logic [7:0] dp_idx_r, dp_idx_nxt;
  logic rd_done_r, rd_done_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] ctrl_a_r, ctrl_b_r, cmp_buf_a_r, cmp_buf_b_r, count_r;
  logic [2:0] flags_r, mask_r;
  logic take, wr_stb;
  logic [7:0] wd;

  // reads take one wait state so a write just ahead is always visible
  assign hreadyout = ~(dp_valid_r & ~dp_write_r & ~rd_done_r);
  assign hresp = 1'b0;
  assign hrdata = {24'h000000, rdata_r};
  assign take = hsel & hready & htrans[1];
  assign wr_stb = dp_valid_r & dp_write_r & dp_ok_r;
  assign wd = hwdata[7:0];

  always_comb begin
    dp_valid_nxt = dp_valid_r;
    dp_write_nxt = dp_write_r;
    dp_ok_nxt = dp_ok_r;
    dp_idx_nxt = dp_idx_r;
    rd_done_nxt = rd_done_r;
    rdata_nxt = rdata_r;
    if (hreadyout) begin
      dp_valid_nxt = take;
      dp_write_nxt = hwrite;
      dp_ok_nxt = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0) &&
                  (hsize == 3'h2);
      dp_idx_nxt = haddr[9:2];
      rd_done_nxt = 1'b0;
    end else begin
      rd_done_nxt = 1'b1;
      rdata_nxt = dp_ok_r ? read_mux(dp_idx_r, ctrl_a_r, ctrl_b_r, count_r,
                                     cmp_buf_a_r, cmp_buf_b_r, flags_r, mask_r)
                          : 8'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_ok_r <= 1'b0;
      dp_idx_r <= 8'h00;
      rd_done_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      dp_valid_r <= dp_valid_nxt;
      dp_write_r <= dp_write_nxt;
      dp_ok_r <= dp_ok_nxt;
      dp_idx_r <= dp_idx_nxt;
      rd_done_r <= rd_done_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ************************************************************
  // software registers
  // ************************************************************
  logic [7:0] ctrl_a_nxt, ctrl_b_nxt, cmp_buf_a_nxt, cmp_buf_b_nxt;
  logic [2:0] flags_nxt, mask_nxt, flag_ev;
  logic [2:0] mode;
  logic [1:0] com_a, com_b;

  assign com_a = ctrl_a_r[`TC8_COM_A_HI:`TC8_COM_A_LO];
  assign com_b = ctrl_a_r[`TC8_COM_B_HI:`TC8_COM_B_LO];
  assign mode = {ctrl_b_r[`TC8_WGM_HI_BIT], ctrl_a_r[1:0]};

  always_comb begin
    ctrl_a_nxt = ctrl_a_r;
    ctrl_b_nxt = ctrl_b_r;
    cmp_buf_a_nxt = cmp_buf_a_r;
    cmp_buf_b_nxt = cmp_buf_b_r;
    mask_nxt = mask_r;
    flags_nxt = flags_r;
    if (wr_stb) begin
      case (dp_idx_r)
        `TC8_IDX_CTRL_A: ctrl_a_nxt = wd & `TC8_CTRL_A_RMASK;
        `TC8_IDX_CTRL_B: ctrl_b_nxt = wd & `TC8_CTRL_B_RMASK;
        `TC8_IDX_CMP_A: cmp_buf_a_nxt = wd;
        `TC8_IDX_CMP_B: cmp_buf_b_nxt = wd;
        `TC8_IDX_MASK: mask_nxt = wd[2:0];
        `TC8_IDX_FLAGS: flags_nxt = flags_r & ~wd[2:0];
        default: flags_nxt = flags_r;
      endcase
    end
    // a new event wins over a write-one clear in the same cycle
    flags_nxt = flags_nxt | flag_ev;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_a_r <= `TC8_CTRL_A_RST;
      ctrl_b_r <= `TC8_CTRL_B_RST;
      cmp_buf_a_r <= 8'h00;
      cmp_buf_b_r <= 8'h00;
      mask_r <= 3'h0;
      flags_r <= 3'h0;
    end else begin
      ctrl_a_r <= ctrl_a_nxt;
      ctrl_b_r <= ctrl_b_nxt;
      cmp_buf_a_r <= cmp_buf_a_nxt;
      cmp_buf_b_r <= cmp_buf_b_nxt;
      mask_r <= mask_nxt;
      flags_r <= flags_nxt;
    end
  end

  assign irq = |(flags_r & mask_r);

  // ************************************************************
  // tick, counter and compare buffers
  // ************************************************************
  logic [PRE_W-1:0] pre_r, pre_nxt;
  logic ext_prev_r, tick, cnt_wr, blk_r, blk_nxt;
  logic [7:0] count_nxt, top, cmp_act_a_r, cmp_act_a_nxt, cmp_act_b_r, cmp_act_b_nxt;
  tc8_pkg::tc8_dir_t dir_r, dir_nxt;
  logic at_limit, wrap_ev, force_a, force_b;
  logic [1:0] match;
  logic [1:0] wave_r, wave_nxt;

  assign cnt_wr = wr_stb && (dp_idx_r == `TC8_IDX_COUNT);
  // the tick only enables the bus clock, so no second clock domain exists
  always_comb begin
    case (ctrl_b_r[2:0])
      3'h1: tick = 1'b1;
      3'h2: tick = (pre_r[2:0] == `TC8_PRE_DIV8);
      3'h3: tick = (pre_r[5:0] == `TC8_PRE_DIV64);
      3'h4: tick = (pre_r[7:0] == `TC8_PRE_DIV256);
      3'h5: tick = (pre_r[9:0] == `TC8_PRE_DIV1024);
      3'h6: tick = ext_prev_r & ~ext_clk_in;
      3'h7: tick = ~ext_prev_r & ext_clk_in;
      default: tick = 1'b0;
    endcase
  end

  // compare A sets the limit in modes 2, 5 and 7
  assign top = (mode == tc8_pkg::TC8_M_CLEAR || mode == tc8_pkg::TC8_M_PHASE_A ||
                mode == tc8_pkg::TC8_M_FAST_A) ? cmp_act_a_r : `TC8_MAX;
  assign at_limit = tick && (count_r == top);
  assign wrap_ev = at_limit && is_fast(mode);
  // a counter write blocks the compare on the next tick
  assign match[0] = tick && !blk_r && (count_r == cmp_act_a_r);
  assign match[1] = tick && !blk_r && (count_r == cmp_act_b_r);
  assign force_a = wr_stb && (dp_idx_r == `TC8_IDX_CTRL_B) && wd[`TC8_FORCE_A_BIT] &&
                   !is_phase(mode) && !is_fast(mode);
  assign force_b = wr_stb && (dp_idx_r == `TC8_IDX_CTRL_B) && wd[`TC8_FORCE_B_BIT] &&
                   !is_phase(mode) && !is_fast(mode);

  always_comb begin
    flag_ev = 3'h0;
    flag_ev[`TC8_FLAG_A] = match[0];
    flag_ev[`TC8_FLAG_B] = match[1];
    if (is_phase(mode)) begin
      flag_ev[`TC8_FLAG_OVF] = tick && (count_r == `TC8_COUNT_FLOOR) &&
                               (dir_r == tc8_pkg::TC8_DOWN);
    end else if (mode == tc8_pkg::TC8_M_FAST_A) begin
      flag_ev[`TC8_FLAG_OVF] = at_limit;
    end else begin
      flag_ev[`TC8_FLAG_OVF] = tick && (count_r == `TC8_MAX);
    end
  end

  always_comb begin
    pre_nxt = PRE_W'(pre_r + 1'b1);
    count_nxt = count_r;
    dir_nxt = dir_r;
    blk_nxt = blk_r;
    cmp_act_a_nxt = cmp_act_a_r;
    cmp_act_b_nxt = cmp_act_b_r;
    if (tick) begin
      blk_nxt = 1'b0;
    end
    if (!is_phase(mode)) begin
      dir_nxt = tc8_pkg::TC8_UP;
    end
    if (cnt_wr) begin
      count_nxt = wd;
      blk_nxt = 1'b1;
    end else if (tick) begin
      if (is_phase(mode)) begin
        case (dir_r)
          tc8_pkg::TC8_UP: begin
            if (count_r == top) begin
              dir_nxt = tc8_pkg::TC8_DOWN;
              count_nxt = (count_r == `TC8_COUNT_FLOOR) ? count_r : 8'(count_r - 8'h01);
            end else begin
              count_nxt = 8'(count_r + 8'h01);
            end
          end
          tc8_pkg::TC8_DOWN: begin
            if (count_r == `TC8_COUNT_FLOOR) begin
              dir_nxt = tc8_pkg::TC8_UP;
              // a limit of zero parks the counter at count_floor
              count_nxt = (count_r == top) ? count_r : 8'(count_r + 8'h01);
            end else begin
              count_nxt = 8'(count_r - 8'h01);
            end
          end
          default: dir_nxt = tc8_pkg::TC8_UP;
        endcase
      end else if ((is_fast(mode) || mode == tc8_pkg::TC8_M_CLEAR) && count_r == top) begin
        count_nxt = `TC8_COUNT_FLOOR;
      end else begin
        count_nxt = 8'(count_r + 8'h01);
      end
    end
    // buffered modes load at the limit tick; fast mode then wraps to count_floor
    if (!is_phase(mode) && !is_fast(mode)) begin
      cmp_act_a_nxt = cmp_buf_a_r;
      cmp_act_b_nxt = cmp_buf_b_r;
    end else if (at_limit) begin
      cmp_act_a_nxt = cmp_buf_a_r;
      cmp_act_b_nxt = cmp_buf_b_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= '0;
      ext_prev_r <= 1'b0;
      count_r <= 8'h00;
      dir_r <= tc8_pkg::TC8_UP;
      blk_r <= 1'b0;
      cmp_act_a_r <= 8'h00;
      cmp_act_b_r <= 8'h00;
    end else begin
      pre_r <= pre_nxt;
      ext_prev_r <= ext_clk_in;
      count_r <= count_nxt;
      dir_r <= dir_nxt;
      blk_r <= blk_nxt;
      cmp_act_a_r <= cmp_act_a_nxt;
      cmp_act_b_r <= cmp_act_b_nxt;
    end
  end

  // ************************************************************
  // wave outputs
  // ************************************************************
  genvar gi;
  for (gi = 0; gi < 2; gi++) begin : g_chan
    always_comb begin
      if (gi == 0) begin
        wave_nxt[gi] = wave_step(wave_r[gi], com_a, mode, 1'b1, match[0] | force_a,
                                 dir_r == tc8_pkg::TC8_UP,
                                 is_fast(mode) ? wrap_ev : at_limit,
                                 com_a[1] && (cmp_act_a_r == top));
      end else begin
        wave_nxt[gi] = wave_step(wave_r[gi], com_b, mode, 1'b0, match[1] | force_b,
                                 dir_r == tc8_pkg::TC8_UP,
                                 is_fast(mode) ? wrap_ev : at_limit,
                                 com_b[1] && (cmp_act_b_r == top));
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_r <= 2'h0;
    end else begin
      wave_r <= wave_nxt;
    end
  end

  assign wave_out_a = wave_r[0];
  assign wave_out_b = wave_r[1];
  assign wave_route_a = |com_a;
  assign wave_route_b = |com_b;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_rd_ctrl_a;
    dp_valid_r && !dp_write_r && !rd_done_r && dp_ok_r && dp_idx_r == `TC8_IDX_CTRL_A;
  endsequence
  sequence s_wr_ctrl_b;
    wr_stb && dp_idx_r == `TC8_IDX_CTRL_B;
  endsequence

  a_tick_stopped: assert property (
    (ctrl_b_r[2:0] == 3'h0 && !cnt_wr) |=> count_r == $past(count_r))
    else $error("counter moved without a tick");
  a_flag_b_set: assert property (match[1] |=> flags_r[`TC8_FLAG_B])
    else $error("match B flag not set");
  a_clear_match: assert property (
    (tick && mode == tc8_pkg::TC8_M_CLEAR && count_r == cmp_act_a_r && !cnt_wr && !blk_r)
    |=> count_r == 8'h00 && flags_r[`TC8_FLAG_A])
    else $error("clear-on-match failed");
  a_route_on: assert property (
    (wr_stb && dp_idx_r == `TC8_IDX_CTRL_A && wd[7:6] != 2'h0) |=> wave_route_a)
    else $error("wave A not routed");
  a_toggle_np: assert property (
    (mode == tc8_pkg::TC8_M_NORMAL && com_a == 2'b01 && match[0]) |=>
    wave_out_a != $past(wave_out_a))
    else $error("wave A did not toggle");
  a_fast_wrap: assert property (
    (is_fast(mode) && com_a == 2'b10 && wrap_ev) |=> wave_out_a)
    else $error("fast wave A not set at wrap");
  a_phase_up: assert property (
    (is_phase(mode) && com_a[1] && match[0] && dir_r == tc8_pkg::TC8_UP &&
     cmp_act_a_r != top) |=> wave_out_a == $past(com_a[0]))
    else $error("phase wave A not cleared");
  a_fast_ignore: assert property (
    (is_fast(mode) && com_b[1] && cmp_act_b_r == top && at_limit) |=>
    wave_out_b != $past(com_b[0]))
    else $error("fast wave B limit case wrong");
  a_phase_ovf: assert property (
    (is_phase(mode) && tick && count_r == 8'h00 && dir_r == tc8_pkg::TC8_DOWN && !cnt_wr)
    |=> flags_r[`TC8_FLAG_OVF] && dir_r == tc8_pkg::TC8_UP)
    else $error("phase overflow flag missing");
  a_resv_zero: assert property (s_rd_ctrl_a |=> hrdata[3:2] == 2'h0 && hreadyout)
    else $error("reserved bits read nonzero");
  a_mode_high: assert property (s_wr_ctrl_b ##0 wd[3] |=> mode[2])
    else $error("mode high bit not taken");

endmodule // tc8_waveform
`default_nettype wire

// *** testbench/tc8_waveform_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "tc8_params.svh"

module tc8_waveform_tb_top;
  // ******************************
  // bench signals
  // ******************************
  localparam logic [7:0] i_ca = `TC8_IDX_CTRL_A;
  localparam logic [7:0] i_cb = `TC8_IDX_CTRL_B;
  localparam logic [7:0] i_cnt = `TC8_IDX_COUNT;
  localparam logic [7:0] i_a = `TC8_IDX_CMP_A;
  localparam logic [7:0] i_b = `TC8_IDX_CMP_B;
  localparam logic [7:0] i_fl = `TC8_IDX_FLAGS;
  localparam logic [7:0] i_mk = `TC8_IDX_MASK;
  logic ref_clk, rst_n, hsel, hwrite, ext_clk_in, rd_ph, pin_stb, rdy_s;
  logic [31:0] haddr, hwdata, hrdata, rd_s, got;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, wave_out_a, wave_route_a, wave_out_b, wave_route_b, irq;
  logic [5:0] pin_s;
  logic [7:0] cb;
  logic [32:0] e;
  logic [32:0] exp_q[$];
  int error_cnt, total_checks, seed;

  tc8_waveform dut (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .ext_clk_in(ext_clk_in),
    .wave_out_a(wave_out_a),
    .wave_route_a(wave_route_a),
    .wave_out_b(wave_out_b),
    .wave_route_b(wave_route_b),
    .irq(irq)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // sample between edges so nothing races the design's flops
  always @(negedge ref_clk) begin
    rdy_s = hreadyout;
    rd_s = hrdata;
    pin_s = {hresp, irq, wave_route_b, wave_out_b, wave_route_a, wave_out_a};
  end

  // ******************************
  // result watcher and tasks
  // ******************************
  always @(posedge ref_clk) begin
    if ((rd_ph && rdy_s) || pin_stb) begin
      got = pin_stb ? {26'h0, pin_s} : rd_s;
      total_checks++;
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("wrong value queue expected note seen none");
      end else begin
        e = exp_q.pop_front();
        if (e[32] !== pin_stb || e[31:0] !== got) begin
          error_cnt++;
          $display("wrong value %s expected %h seen %h", pin_stb ? "pins" : "hrdata", e[31:0], got);
        end
      end
    end
  end

  task automatic test_done();
    if (exp_q.size() != 0) error_cnt++;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge ref_clk);
    while (rdy_s !== 1'b1) begin
      n++;
      if (n > 50) begin
        error_cnt++;
        $display("wrong value hready expected 1 seen timeout");
        test_done();
      end
      @(posedge ref_clk);
    end
  endtask

  // one single word transfer; a read leaves its expected byte in the queue
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
    haddr <= {22'h0, i, 2'b00};
    hwrite <= w;
    hsel <= 1'b1;
    htrans <= 2'b10;
    if (!w) exp_q.push_back({9'h0, 16'h0, d});
    wait_rdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= w ? {24'h0, d} : 32'h0;
    rd_ph <= !w;
    wait_rdy();
    rd_ph <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    bus(1'b1, i, d);
  endtask

  task automatic rd(input logic [7:0] i, input logic [7:0] d);
    bus(1'b0, i, d);
  endtask

  task automatic pins(input logic [4:0] x);
    exp_q.push_back({1'b1, 27'h0, x});
    pin_stb <= 1'b1;
    @(posedge ref_clk);
    pin_stb <= 1'b0;
    @(posedge ref_clk);
  endtask

  // external rising edges give exact tick counts; idle input means no ticks
  task automatic tick(input int n);
    repeat (n) begin
      ext_clk_in <= 1'b1;
      repeat (2) @(posedge ref_clk);
      ext_clk_in <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
    repeat (4) @(posedge ref_clk);
  endtask

  initial begin
    seed = 28;
    error_cnt = 0;
    total_checks = 0;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    ext_clk_in = 1'b0;
    rd_ph = 1'b0;
    pin_stb = 1'b0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(i_ca, 8'h00);
    rd(i_cb, 8'h00);
    rd(i_fl, 8'h00);
    rd(i_mk, 8'h00);
    pins(5'h00);
    wr(i_ca, 8'hFF);
    rd(i_ca, 8'hF3);
    pins(5'h0A);
    rd(8'h30, 8'h00);
    wr(i_cb, 8'hC8);
    rd(i_cb, 8'h08);
    wr(i_ca, 8'h00);
    wr(i_cb, 8'h07);
    // normal mode: toggle on A, set on B, random compare B
    cb = 8'h20 + 8'($random(seed) & 32'h1F);
    wr(i_cnt, 8'h00);
    wr(i_a, 8'h10);
    wr(i_b, cb);
    wr(i_ca, 8'h70);
    tick(72);
    rd(i_cnt, 8'h48);
    rd(i_fl, 8'h06);
    pins(5'h0F);
    wr(i_mk, 8'h02);
    pins(5'h1F);
    wr(i_fl, 8'h02);
    pins(5'h0F);
    rd(i_fl, 8'h04);
    wr(i_mk, 8'h00);
    // clear-on-match: period of 16 ticks, no overflow
    wr(i_fl, 8'h07);
    wr(i_cnt, 8'h00);
    wr(i_a, 8'h0F);
    wr(i_ca, 8'h82);
    tick(300);
    rd(i_fl, 8'h02);
    rd(i_cnt, 8'h0C);
    pins(5'h06);
    // fast PWM to 0xFF: A non-inverting, B inverting
    wr(i_a, 8'h40);
    wr(i_b, 8'h80);
    wr(i_cnt, 8'h00);
    wr(i_ca, 8'hB3);
    wr(i_fl, 8'h07);
    tick(256);
    pins(5'h0B);
    rd(i_fl, 8'h07);
    rd(i_cnt, 8'h00);
    tick(65);
    pins(5'h0A);
    tick(64);
    pins(5'h0E);
    // phase-correct to 0xFF: A inverting, B non-inverting
    wr(i_ca, 8'h00);
    wr(i_a, 8'h20);
    wr(i_b, 8'h30);
    wr(i_cnt, 8'h00);
    wr(i_fl, 8'h07);
    wr(i_ca, 8'hE1);
    tick(49);
    pins(5'h0B);
    tick(431);
    pins(5'h0E);
    rd(i_fl, 8'h06);
    tick(32);
    rd(i_fl, 8'h07);
    // fast PWM with compare A as limit, A toggles, B non-inverting
    wr(i_ca, 8'h00);
    wr(i_a, 8'h07);
    wr(i_b, 8'h03);
    wr(i_cnt, 8'h00);
    wr(i_fl, 8'h07);
    wr(i_ca, 8'h63);
    wr(i_cb, 8'h0F);
    tick(8);
    pins(5'h0F);
    rd(i_cnt, 8'h00);
    rd(i_fl, 8'h07);
    tick(4);
    pins(5'h0B);
    tick(4);
    pins(5'h0E);
    // compare equal to limit: match ignored, wrap sets A and clears inverting B
    wr(i_cb, 8'h07);
    wr(i_ca, 8'h00);
    wr(i_a, 8'hFF);
    wr(i_b, 8'hFF);
    wr(i_cnt, 8'h00);
    wr(i_ca, 8'hB3);
    tick(256);
    pins(5'h0B);
    // phase-correct with compare at the limit: inverting A clears at the top
    wr(i_ca, 8'hC1);
    tick(256);
    pins(5'h02);
    test_done();
  end
endmodule // tc8_waveform_tb_top
`default_nettype wire
